// ===== pkg/astr_map.svh
// Register offsets, field positions, reset values and bit timing counts of the serial core.
`ifndef ASTR_MAP_SVH
`define ASTR_MAP_SVH
`define ASTR_ADDR_W 3
`define ASTR_DATA_W 8
`define ASTR_OFF_CTRL1 3'h0
`define ASTR_OFF_CTRL2 3'h1
`define ASTR_OFF_CTRL3 3'h2
`define ASTR_OFF_STAT1 3'h3
`define ASTR_OFF_STAT2 3'h4
`define ASTR_OFF_DATA 3'h5
`define ASTR_OFF_BAUD 3'h6
`define ASTR_C1_MOD_EN 6
`define ASTR_C1_TX_INV 5
`define ASTR_C1_LEN9 4
`define ASTR_C2_TX_IE 7
`define ASTR_C2_TC_IE 6
`define ASTR_C2_RX_IE 5
`define ASTR_C2_TX_EN 3
`define ASTR_C2_RX_EN 2
`define ASTR_C2_SBK 0
`define ASTR_C3_RX_NINTH 7
`define ASTR_C3_TX_NINTH 6
`define ASTR_S1_TX_EMPTY 7
`define ASTR_S1_TC 6
`define ASTR_S1_RX_FULL 5
`define ASTR_S1_NOISE 2
`define ASTR_S1_FE 1
`define ASTR_S2_BKF 1
`define ASTR_S2_RPF 0
`define ASTR_RST_BAUD_DIV 8'h00
`define ASTR_TX_RT_LAST 4'hF
`define ASTR_TX_BITS_8 4'hA
`define ASTR_TX_BITS_9 4'hB
`define ASTR_RX_BITS_8 4'h8
`define ASTR_RX_BITS_9 4'h9
`define ASTR_RT_ONE 5'h01
`define ASTR_RT_V1 5'h03
`define ASTR_RT_V2 5'h05
`define ASTR_RT_V3 5'h07
`define ASTR_RT_M1 5'h08
`define ASTR_RT_M2 5'h09
`define ASTR_RT_M3 5'h0A
`define ASTR_RT_RESYNC_MAX 5'h04
`define ASTR_RT_LAST 5'h10
`endif

// ===== pkg/astr_pkg.sv
// Types and helper function of the serial core.
package astr_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_DATA, TX_BREAK, TX_POST} astr_tx_state_t;
  typedef enum logic [1:0] {RX_SEARCH, RX_START, RX_DATA, RX_STOP} astr_rx_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } astr_bus_req_t;

  typedef struct packed {
    logic mod_en;
    logic tx_inv;
    logic len9;
    logic tx_ie;
    logic tc_ie;
    logic rx_ie;
    logic tx_en;
    logic rx_en;
    logic send_break_bit;
    logic tx_ninth;
  } astr_ctrl_t;

  typedef struct packed {
    astr_ctrl_t c;
    logic [7:0] baud_div;
    logic [7:0] div_cnt;
    logic div_half;
    astr_tx_state_t tx_state;
    logic [10:0] tx_shift;
    logic [3:0] tx_bits;
    logic [3:0] tx_rt;
    logic [7:0] tx_buf;
    logic tx_empty;
    logic tc;
    logic tx_arm;
    logic tx_pre;
    logic tx_en_d;
    astr_rx_state_t rx_state;
    logic [4:0] rx_rt;
    logic [2:0] rx_hist;
    logic [1:0] rx_smp;
    logic [8:0] rx_shift;
    logic [3:0] rx_bits;
    logic rx_last;
    logic rx_prev;
    logic rx_nacc;
    logic [7:0] rx_buf;
    logic rx_ninth;
    logic rx_full;
    logic noise;
    logic fe;
    logic break_detect_flag;
    logic rx_arm;
    logic brk_arm;
    logic [2:0] sync;
    logic rx_filt;
    logic [7:0] rdata;
    logic tx_irq;
    logic rx_irq;
    logic tx_out;
    logic tx_oe;
  } astr_state_t;

  function automatic logic astr_maj3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction : astr_maj3
endpackage : astr_pkg

// ===== src/astr_core.sv
// Full-duplex asynchronous serial transmitter and receiver with register port.
//
// Behaviour
// - Transmit 8 or 9 bit characters; ninth bit comes from tx_ninth_bit.
// - A transmission starts with an all-ones preamble, then the buffered word loads.
// - Data frames carry a low start bit first and a high stop bit last.
// - Buffer hand-off sets tx_empty_flag; request raised with tx_empty_irq_enable.
// - With tx_polarity_invert clear, the transmit line idles high when no character is shifting.
// - Clearing module_enable_bit releases the transmit pin at once.
// - While send_break_bit is set, all-zero break characters keep loading.
// - After break clears, finish the break then send at least one high bit.
// - Start, eight or nine zero data bits and a zero stop form a break.
// - A break sets framing, full and break flags and clears data and ninth bit.
// - Idle characters are all ones of character length; the preamble is one.
// - Clearing transmitter enable finishes the current character, then idles the line.
// - Toggling transmitter enable during a character queues one idle character next.
// - tx_polarity_invert inverts every transmitted level including idle and break.
// - tx_complete_flag sets when shifter and buffer are empty with no break.
// - Receive 8 or 9 bits; rx_ninth_bit is bit 8, or bit 7 copy.
// - A finished character moves to the read buffer and sets rx_full_flag.
// - Sample at sixteen ticks per bit; resync after start and falling data edges.
// - A start edge is a low sample after three high samples.
// - Start is verified at ticks 3, 5, 7; one high sets noise.
// - A failed start verification resets the tick count and searches again.
// - Data bits are the majority of ticks 8, 9, 10; disagreement sets noise.
// - Stop bit majority low sets framing error; disagreement sets noise.
`timescale 1ns/1ns
`default_nettype none
`include "astr_map.svh"

module astr_core
  import astr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire astr_bus_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic baud_clock_source_select,
  input wire logic rx_in,
  output logic tx_out,
  output logic tx_oe,
  output logic tx_irq,
  output logic rx_irq
);

  astr_state_t st_reg;
  astr_state_t st_next;
  logic tick;
  logic pick;
  logic te_rise;
  logic load_data;
  logic load_break;
  logic start_fail;
  logic rx_done;
  logic rx_brk;
  logic maj;
  logic level;
  logic [1:0] ones;
  logic [4:0] rt_n;
  logic [3:0] nbits;

  always_comb
  begin
    st_next = st_reg;
    tick = 1'b0;
    pick = 1'b0;
    te_rise = 1'b0;
    load_data = 1'b0;
    load_break = 1'b0;
    start_fail = 1'b0;
    rx_done = 1'b0;
    rx_brk = 1'b0;
    maj = astr_maj3(st_reg.rx_smp[0], st_reg.rx_smp[1], st_reg.rx_filt);
    ones = {1'b0, st_reg.rx_smp[0]} + {1'b0, st_reg.rx_smp[1]} + {1'b0, st_reg.rx_filt};
    rt_n = st_reg.rx_rt + `ASTR_RT_ONE;
    nbits = st_reg.c.len9 ? `ASTR_TX_BITS_9 : `ASTR_TX_BITS_8;
    level = 1'b1;

    // Register writes.
    if (reg_req.wr)
    begin
      case (reg_req.addr)
        `ASTR_OFF_CTRL1:
        begin
          st_next.c.mod_en = reg_req.wdata[`ASTR_C1_MOD_EN];
          st_next.c.tx_inv = reg_req.wdata[`ASTR_C1_TX_INV];
          st_next.c.len9 = reg_req.wdata[`ASTR_C1_LEN9];
        end
        `ASTR_OFF_CTRL2:
        begin
          st_next.c.tx_ie = reg_req.wdata[`ASTR_C2_TX_IE];
          st_next.c.tc_ie = reg_req.wdata[`ASTR_C2_TC_IE];
          st_next.c.rx_ie = reg_req.wdata[`ASTR_C2_RX_IE];
          st_next.c.tx_en = reg_req.wdata[`ASTR_C2_TX_EN];
          st_next.c.rx_en = reg_req.wdata[`ASTR_C2_RX_EN];
          st_next.c.send_break_bit = reg_req.wdata[`ASTR_C2_SBK];
        end
        `ASTR_OFF_CTRL3: st_next.c.tx_ninth = reg_req.wdata[`ASTR_C3_TX_NINTH];
        `ASTR_OFF_DATA:
        begin
          st_next.tx_buf = reg_req.wdata;
          // The empty flag only clears after a status one read armed it.
          if (st_reg.tx_arm)
          begin
            st_next.tx_empty = 1'b0;
            st_next.tc = 1'b0;
            st_next.tx_arm = 1'b0;
          end
        end
        `ASTR_OFF_BAUD: st_next.baud_div = reg_req.wdata;
        default: ;
      endcase
    end

    // Register reads; data stands for exactly the cycle after the strobe.
    st_next.rdata = 8'h00;
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        `ASTR_OFF_CTRL1:
        begin
          st_next.rdata[`ASTR_C1_MOD_EN] = st_reg.c.mod_en;
          st_next.rdata[`ASTR_C1_TX_INV] = st_reg.c.tx_inv;
          st_next.rdata[`ASTR_C1_LEN9] = st_reg.c.len9;
        end
        `ASTR_OFF_CTRL2:
        begin
          st_next.rdata[`ASTR_C2_TX_IE] = st_reg.c.tx_ie;
          st_next.rdata[`ASTR_C2_TC_IE] = st_reg.c.tc_ie;
          st_next.rdata[`ASTR_C2_RX_IE] = st_reg.c.rx_ie;
          st_next.rdata[`ASTR_C2_TX_EN] = st_reg.c.tx_en;
          st_next.rdata[`ASTR_C2_RX_EN] = st_reg.c.rx_en;
          st_next.rdata[`ASTR_C2_SBK] = st_reg.c.send_break_bit;
        end
        `ASTR_OFF_CTRL3:
        begin
          st_next.rdata[`ASTR_C3_RX_NINTH] = st_reg.rx_ninth;
          st_next.rdata[`ASTR_C3_TX_NINTH] = st_reg.c.tx_ninth;
        end
        `ASTR_OFF_STAT1:
        begin
          st_next.rdata[`ASTR_S1_TX_EMPTY] = st_reg.tx_empty;
          st_next.rdata[`ASTR_S1_TC] = st_reg.tc;
          st_next.rdata[`ASTR_S1_RX_FULL] = st_reg.rx_full;
          st_next.rdata[`ASTR_S1_NOISE] = st_reg.noise;
          st_next.rdata[`ASTR_S1_FE] = st_reg.fe;
          st_next.tx_arm = 1'b1;
          st_next.rx_arm = 1'b1;
        end
        `ASTR_OFF_STAT2:
        begin
          st_next.rdata[`ASTR_S2_BKF] = st_reg.break_detect_flag;
          st_next.rdata[`ASTR_S2_RPF] = st_reg.rx_state != RX_SEARCH;
          st_next.brk_arm = 1'b1;
        end
        `ASTR_OFF_DATA:
        begin
          st_next.rdata = st_reg.rx_buf;
          if (st_reg.rx_arm)
          begin
            st_next.rx_full = 1'b0;
            st_next.noise = 1'b0;
            st_next.fe = 1'b0;
            st_next.rx_arm = 1'b0;
          end
          if (st_reg.brk_arm)
          begin
            st_next.break_detect_flag = 1'b0;
            st_next.brk_arm = 1'b0;
          end
        end
        `ASTR_OFF_BAUD: st_next.rdata = st_reg.baud_div;
        default: ;
      endcase
    end

    // Sixteen-times baud tick; the slow source advances on every other clock.
    if (baud_clock_source_select || st_reg.div_half)
    begin
      if (st_reg.div_cnt == 8'h00)
      begin
        tick = 1'b1;
        st_next.div_cnt = st_reg.baud_div;
      end
      else
      begin
        st_next.div_cnt = st_reg.div_cnt - 8'h01;
      end
    end
    st_next.div_half = ~st_reg.div_half;

    // Receive line synchroniser; the filtered level moves when stages two and three agree.
    st_next.sync = {st_reg.sync[1:0], rx_in};
    if (st_reg.sync[1] == st_reg.sync[2])
    begin
      st_next.rx_filt = st_reg.sync[2];
    end

    // Transmitter.
    st_next.tx_en_d = st_reg.c.tx_en;
    te_rise = st_reg.c.tx_en && !st_reg.tx_en_d;
    if (te_rise)
    begin
      st_next.tx_pre = 1'b1;
    end
    case (st_reg.tx_state)
      TX_IDLE: pick = st_reg.c.mod_en;
      default:
      begin
        level = st_reg.tx_shift[0];
        if (tick)
        begin
          if (st_reg.tx_rt == `ASTR_TX_RT_LAST)
          begin
            st_next.tx_rt = 4'h0;
            st_next.tx_shift = {1'b1, st_reg.tx_shift[10:1]};
            st_next.tx_bits = st_reg.tx_bits - 4'h1;
            pick = st_reg.tx_bits == 4'h1;
          end
          else
          begin
            st_next.tx_rt = st_reg.tx_rt + 4'h1;
          end
        end
      end
    endcase
    if (pick)
    begin
      st_next.tx_state = TX_IDLE;
      st_next.tx_rt = 4'h0;
      if (st_reg.c.tx_en && st_reg.c.send_break_bit)
      begin
        load_break = 1'b1;
        st_next.tx_state = TX_BREAK;
        st_next.tx_shift = 11'h000;
        st_next.tx_bits = nbits;
      end
      else if (st_reg.tx_state == TX_BREAK)
      begin
        st_next.tx_state = TX_POST;
        st_next.tx_shift = 11'h7FF;
        st_next.tx_bits = 4'h1;
      end
      else if (st_reg.c.tx_en && (st_reg.tx_pre || te_rise))
      begin
        st_next.tx_state = TX_PRE;
        st_next.tx_shift = 11'h7FF;
        st_next.tx_bits = nbits;
        st_next.tx_pre = 1'b0;
      end
      else if (st_reg.c.tx_en && !st_reg.tx_empty)
      begin
        load_data = 1'b1;
        st_next.tx_state = TX_DATA;
        st_next.tx_bits = nbits;
        st_next.tx_shift = {1'b1, st_reg.c.len9 ? st_reg.c.tx_ninth : 1'b1, st_reg.tx_buf,
                            1'b0};
        st_next.tx_empty = 1'b1;
      end
    end
    if (st_next.tx_state == TX_IDLE && st_next.tx_empty && !st_reg.c.send_break_bit)
    begin
      st_next.tc = 1'b1;
    end

    // Receiver; every step runs on the sample tick, except the disable reset, which acts on every clock.
    if (tick)
    begin
      st_next.rx_prev = st_reg.rx_filt;
      case (st_reg.rx_state)
        RX_SEARCH:
        begin
          st_next.rx_hist = {st_reg.rx_hist[1:0], st_reg.rx_filt};
          if (st_reg.rx_hist == 3'h7 && !st_reg.rx_filt)
          begin
            st_next.rx_state = RX_START;
            st_next.rx_rt = `ASTR_RT_ONE;
            st_next.rx_nacc = 1'b0;
            st_next.rx_shift = 9'h000;
          end
        end
        RX_START:
        begin
          st_next.rx_rt = rt_n;
          if (rt_n == `ASTR_RT_V1)
          begin
            st_next.rx_smp[0] = st_reg.rx_filt;
          end
          if (rt_n == `ASTR_RT_V2)
          begin
            st_next.rx_smp[1] = st_reg.rx_filt;
          end
          if (rt_n == `ASTR_RT_V3)
          begin
            if (ones >= 2'h2)
            begin
              start_fail = 1'b1;
              st_next.rx_state = RX_SEARCH;
              st_next.rx_rt = 5'h00;
              st_next.rx_hist = 3'h0;
            end
            else
            begin
              st_next.rx_nacc = ones == 2'h1;
            end
          end
          if (rt_n == `ASTR_RT_LAST)
          begin
            st_next.rx_state = RX_DATA;
            st_next.rx_rt = 5'h00;
            st_next.rx_bits = 4'h0;
            st_next.rx_last = 1'b0;
          end
        end
        default:
        begin
          st_next.rx_rt = rt_n;
          if (rt_n == `ASTR_RT_M1)
          begin
            st_next.rx_smp[0] = st_reg.rx_filt;
          end
          if (rt_n == `ASTR_RT_M2)
          begin
            st_next.rx_smp[1] = st_reg.rx_filt;
          end
          if (rt_n == `ASTR_RT_M3 && st_reg.rx_state == RX_DATA)
          begin
            st_next.rx_shift = {maj, st_reg.rx_shift[8:1]};
            st_next.rx_nacc = st_reg.rx_nacc | (ones != 2'h0 && ones != 2'h3);
            st_next.rx_last = maj;
          end
          if (st_reg.rx_state == RX_DATA && st_reg.rx_last && st_reg.rx_prev &&
              !st_reg.rx_filt && rt_n <= `ASTR_RT_RESYNC_MAX)
          begin
            st_next.rx_rt = `ASTR_RT_ONE;
          end
          if (rt_n == `ASTR_RT_LAST && st_reg.rx_state == RX_DATA)
          begin
            st_next.rx_rt = 5'h00;
            st_next.rx_bits = st_reg.rx_bits + 4'h1;
            if (st_reg.rx_bits + 4'h1 == (st_reg.c.len9 ? `ASTR_RX_BITS_9 : `ASTR_RX_BITS_8))
            begin
              st_next.rx_state = RX_STOP;
            end
          end
          if (rt_n == `ASTR_RT_M3 && st_reg.rx_state == RX_STOP)
          begin
            rx_done = 1'b1;
            rx_brk = !maj && (st_reg.c.len9 ? st_reg.rx_shift == 9'h000 :
                              st_reg.rx_shift[8:1] == 8'h00);
            st_next.rx_state = RX_SEARCH;
            st_next.rx_rt = 5'h00;
            st_next.rx_hist = {maj, maj, maj};
            st_next.rx_full = 1'b1;
            if (!maj)
            begin
              st_next.fe = 1'b1;
            end
            if (st_reg.rx_nacc || (ones != 2'h0 && ones != 2'h3))
            begin
              st_next.noise = 1'b1;
            end
            if (rx_brk)
            begin
              st_next.break_detect_flag = 1'b1;
              st_next.rx_buf = 8'h00;
              st_next.rx_ninth = 1'b0;
            end
            else
            begin
              st_next.rx_buf = st_reg.c.len9 ? st_reg.rx_shift[7:0] : st_reg.rx_shift[8:1];
              st_next.rx_ninth = st_reg.rx_shift[8];
            end
          end
        end
      endcase
    end
    if (!st_reg.c.mod_en || !st_reg.c.rx_en)
    begin
      st_next.rx_state = RX_SEARCH;
      st_next.rx_rt = 5'h00;
    end
    if (!st_reg.c.mod_en)
    begin
      st_next.tx_state = TX_IDLE;
      st_next.tx_rt = 4'h0;
    end

    // Pin drive is open-drain: only a low level is driven.
    st_next.tx_out = level ^ st_reg.c.tx_inv;
    st_next.tx_oe = st_reg.c.mod_en && (st_reg.c.tx_en || st_reg.tx_state != TX_IDLE) &&
                    !(level ^ st_reg.c.tx_inv);
    st_next.tx_irq = (st_reg.tx_empty && st_reg.c.tx_ie) || (st_reg.tc && st_reg.c.tc_ie);
    st_next.rx_irq = st_reg.rx_full && st_reg.c.rx_ie;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '0;
      st_reg.tx_empty <= 1'b1;
      st_reg.tc <= 1'b1;
      st_reg.baud_div <= `ASTR_RST_BAUD_DIV;
      st_reg.sync <= 3'h7;
      st_reg.rx_filt <= 1'b1;
      st_reg.rx_prev <= 1'b1;
      st_reg.tx_out <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign tx_out = st_reg.tx_out;
  assign tx_oe = st_reg.tx_oe;
  assign tx_irq = st_reg.tx_irq;
  assign rx_irq = st_reg.rx_irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_nine_bit_frame: assert property ((load_data && st_reg.c.len9) |=>
    (st_reg.tx_bits == 4'hB && st_reg.tx_shift[9] == $past(st_reg.c.tx_ninth)))
    else $error("nine bit frame wrong");
  a_preamble_first: assert property ((pick && te_rise && !(st_reg.c.send_break_bit) && st_reg.c.mod_en &&
    st_reg.tx_state != TX_BREAK) |=>
    st_reg.tx_state == TX_PRE)
    else $error("preamble not sent first");
  a_start_bit_low: assert property (load_data |=> (!st_reg.tx_shift[0] && st_reg.tx_shift[10]))
    else $error("start or stop bit wrong");
  a_empty_on_load: assert property (load_data |=> st_reg.tx_empty)
    else $error("empty flag not set on load");
  a_idle_line_high: assert property ((st_reg.tx_state == TX_IDLE && !st_reg.c.tx_inv) |=>
    (!tx_oe && tx_out))
    else $error("idle line not high");
  a_disable_release: assert property (!st_reg.c.mod_en |=> (!tx_oe && st_reg.tx_state == TX_IDLE
    && st_reg.rx_state == RX_SEARCH))
    else $error("pin not released");
  a_break_zero: assert property (load_break |=> (st_reg.tx_shift == 11'h000))
    else $error("break character not zero");
  a_post_break: assert property ((pick && st_reg.tx_state == TX_BREAK && !st_reg.c.send_break_bit &&
    st_reg.c.mod_en) |=>
    (st_reg.tx_state == TX_POST && st_reg.tx_shift[0]))
    else $error("no high bit after break");
  a_rx_break_flags: assert property (rx_brk |=> (st_reg.break_detect_flag && st_reg.fe && st_reg.rx_full &&
    st_reg.rx_buf == 8'h00 && !st_reg.rx_ninth))
    else $error("break flags wrong");
  a_invert_idle: assert property ((st_reg.tx_state == TX_IDLE && st_reg.c.mod_en &&
    st_reg.c.tx_en && st_reg.c.tx_inv) |=> (tx_oe && !tx_out))
    else $error("inverted idle not driven low");
  a_rx_ninth: assert property ((rx_done && !rx_brk) |=>
    st_reg.rx_ninth == $past(st_reg.rx_shift[8]))
    else $error("ninth bit wrong");
  a_rx_full_irq: assert property (rx_done |=> st_reg.rx_full ##1 (rx_irq == st_reg.c.rx_ie))
    else $error("rx full or request missing");
  a_start_reject: assert property (start_fail |=> (st_reg.rx_state == RX_SEARCH &&
    st_reg.rx_rt == 5'h00))
    else $error("failed start not rejected");
  a_stop_framing: assert property ((rx_done && !maj) |=> st_reg.fe)
    else $error("framing error not set");

  c_data_sent: cover property (load_data ##[1:400] pick);
  c_break_rx: cover property (rx_brk);
  c_start_fail: cover property (start_fail);
  c_break_tx: cover property (load_break);

endmodule : astr_core
`default_nettype wire

// ===== bench/astr_remote.sv
// Model of the remote serial device that faces the core on its receive and transmit lines.
`timescale 1ns/1ns
`default_nettype none
module astr_remote (
  input wire logic clk,
  input wire logic line,
  input wire logic [3:0] nbits,
  output logic rx_line
);
  logic [7:0] cnt = 8'h00;
  logic [3:0] idx = 4'h0;
  logic [10:0] frame = 11'h000;
  int frames = 0;

  initial rx_line = 1'b1;

  // A frame starts at the first low level on an idle line; each bit is read at mid-bit.
  always @(posedge clk)
  begin
    if (cnt == 8'h00)
    begin
      idx <= 4'h0;
      if (line == 1'b0)
        cnt <= 8'h01;
    end
    else if (cnt[3:0] == 4'h8 && idx == nbits - 4'h1)
    begin
      frame[idx] <= line;
      frames <= frames + 1;
      cnt <= 8'h00;
    end
    else
    begin
      if (cnt[3:0] == 4'h8)
      begin
        frame[idx] <= line;
        idx <= idx + 4'h1;
      end
      cnt <= cnt + 8'h01;
    end
  end

  // Sends n bits of 16 clocks each, LSB first; bit number glitch gets a two-clock spike.
  // The spike must last two clocks to pass the input filter, and it is placed so that only
  // the tenth sample of the bit sees it, which leaves the majority intact.
  task automatic send(input logic [10:0] bits, input int n, input int glitch);
    for (int i = 0; i < n; i++)
    begin
      rx_line <= bits[i];
      repeat (9) @(posedge clk);
      if (i == glitch)
        rx_line <= ~bits[i];
      repeat (2) @(posedge clk);
      rx_line <= bits[i];
      repeat (5) @(posedge clk);
    end
    rx_line <= 1'b1;
  endtask : send

  task automatic pulse(input int n);
    rx_line <= 1'b0;
    repeat (n) @(posedge clk);
    rx_line <= 1'b1;
  endtask : pulse
endmodule : astr_remote
`default_nettype wire

// ===== bench/astr_core_bench.sv
// Self-checking testbench of the serial core with a remote device model.
`timescale 1ns/1ns
`default_nettype none
`include "astr_map.svh"
module astr_core_bench;
  import astr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  astr_bus_req_t req = '0;
  logic [7:0] rdata;
  logic rx_in;
  logic tx_out;
  logic tx_oe;
  logic tx_irq;
  logic rx_irq;
  logic [3:0] nbits = 4'hA;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  int seen;
  // Open-drain transmit line with a pull-up.
  wire tx_line = tx_oe ? 1'b0 : 1'b1;

  always #10 clk = ~clk;

  astr_core i_dut (.clk(clk), .rst(rst), .reg_req(req), .reg_rdata(rdata),
    .baud_clock_source_select(1'b1), .rx_in(rx_in), .tx_out(tx_out), .tx_oe(tx_oe),
    .tx_irq(tx_irq), .rx_irq(rx_irq));
  astr_remote i_remote (.clk(clk), .line(tx_line), .nbits(nbits), .rx_line(rx_in));

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk($sformatf("reg %0d", a), {3'h0, e}, {3'h0, rdata & m});
  endtask : rd

  task automatic wait_frame(input int old);
    for (int i = 0; i < 600 && i_remote.frames == old; i++)
      cyc(1);
  endtask : wait_frame

  task automatic wait_line(input logic lvl);
    for (int i = 0; i < 400 && tx_line !== lvl; i++)
      cyc(1);
  endtask : wait_line

  // Cuts a hung run short.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      fails++;
      close_out();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    chk("tx_out", 11'h1, {10'h0, tx_out});
    chk("tx_oe", 11'h0, {10'h0, tx_oe});
    rd(`ASTR_OFF_STAT1, 8'hFF, 8'hC0);
    rd(3'h7, 8'hFF, 8'h00);
    wr(`ASTR_OFF_CTRL1, 8'h40);
    wr(`ASTR_OFF_CTRL2, 8'h88);
    rd(`ASTR_OFF_STAT1, 8'h80, 8'h80);
    seen = i_remote.frames;
    wr(`ASTR_OFF_DATA, 8'hA5);
    cyc(2);
    chk("tx_irq low", 11'h0, {10'h0, tx_irq});
    cyc(150);
    chk("preamble", 11'(seen), 11'(i_remote.frames));
    wait_frame(seen);
    chk("frame8", {2'b01, 8'hA5, 1'b0}, {1'b0, i_remote.frame[9:0]});
    chk("tx_irq", 11'h1, {10'h0, tx_irq});
    cyc(20);
    rd(`ASTR_OFF_STAT1, 8'hFF, 8'hC0);
    wr(`ASTR_OFF_CTRL1, 8'h50);
    wr(`ASTR_OFF_CTRL3, 8'h40);
    nbits <= 4'hB;
    rd(`ASTR_OFF_STAT1, 8'h80, 8'h80);
    seen = i_remote.frames;
    wr(`ASTR_OFF_DATA, 8'h3C);
    wait_frame(seen);
    chk("frame9", {2'b11, 8'h3C, 1'b0}, i_remote.frame);
    wr(`ASTR_OFF_CTRL1, 8'h40);
    nbits <= 4'hA;
    cyc(40);
    wr(`ASTR_OFF_CTRL2, 8'h09);
    cyc(60);
    chk("break", 11'h0, {10'h0, tx_line});
    cyc(200);
    chk("break held", 11'h0, {10'h0, tx_line});
    wr(`ASTR_OFF_CTRL2, 8'h08);
    wait_line(1'b1);
    cyc(15);
    chk("after break", 11'h1, {10'h0, tx_line});
    cyc(200);
    wr(`ASTR_OFF_CTRL1, 8'h60);
    cyc(40);
    chk("inverted idle", 11'h0, {10'h0, tx_out});
    wr(`ASTR_OFF_CTRL1, 8'h40);
    cyc(200);
    rd(`ASTR_OFF_STAT1, 8'h80, 8'h80);
    wr(`ASTR_OFF_DATA, 8'h00);
    wait_line(1'b0);
    cyc(20);
    wr(`ASTR_OFF_CTRL1, 8'h00);
    cyc(2);
    chk("oe off", 11'h0, {10'h0, tx_oe});
    wr(`ASTR_OFF_CTRL1, 8'h40);
    cyc(2);
    chk("restart idle", 11'h1, {10'h0, tx_line});
    wr(`ASTR_OFF_CTRL2, 8'h24);
    cyc(200);
    i_remote.send({2'b01, 8'h96, 1'b0}, 10, 99);
    cyc(20);
    chk("rx_irq", 11'h1, {10'h0, rx_irq});
    rd(`ASTR_OFF_STAT1, 8'h26, 8'h20);
    rd(`ASTR_OFF_DATA, 8'hFF, 8'h96);
    rd(`ASTR_OFF_CTRL3, 8'h80, 8'h80);
    i_remote.send(11'h000, 10, 99);
    cyc(20);
    rd(`ASTR_OFF_STAT1, 8'h26, 8'h22);
    rd(`ASTR_OFF_STAT2, 8'h02, 8'h02);
    rd(`ASTR_OFF_DATA, 8'hFF, 8'h00);
    rd(`ASTR_OFF_CTRL3, 8'h80, 8'h00);
    i_remote.pulse(2);
    cyc(40);
    rd(`ASTR_OFF_STAT1, 8'h20, 8'h00);
    i_remote.send({2'b01, 8'h55, 1'b0}, 10, 3);
    cyc(20);
    rd(`ASTR_OFF_STAT1, 8'h26, 8'h24);
    rd(`ASTR_OFF_DATA, 8'hFF, 8'h55);
    close_out();
  end
endmodule : astr_core_bench
`default_nettype wire
